// ### src/uolc_pkg.sv
`default_nettype none
package uolc_pkg;
   // Register map
   localparam logic [7:0] REG_CTRL_OFS = 8'h00;
   localparam logic [7:0] REG_STAT_OFS = 8'h04;
   localparam logic [7:0] REG_CTRL_RST = 8'h00;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
   // Control field positions
   localparam int DPU_BIT = 7;
   localparam int DMU_BIT = 6;
   localparam int DPD_BIT = 5;
   localparam int DMD_BIT = 4;
   localparam int VON_BIT = 3;
   localparam int OWN_BIT = 2;
   localparam int CHG_BIT = 1;
   localparam int DIS_BIT = 0;
   localparam int CTRL_W = 8;
   // Bus answer latency in cycles of waitrequest high
   localparam int BUS_WAIT_CYC = 1;
   // Bus state machine
   typedef enum logic [2:0] {
      UOLC_IDLE = 3'b001,
      UOLC_ACK = 3'b010,
      UOLC_DONE = 3'b100
   } uolc_bus_e;
endpackage
`default_nettype wire

// ### src/uolc_pull_mux.sv
`default_nettype none
// Registered selection of the four data-line pull controls
module uolc_pull_mux
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Selection
   input wire logic sw_own_in,
   input wire logic [3:0] sw_pull_in,
   input wire logic [3:0] hw_pull_in,
   // Result
   output logic [3:0] pull_out
);
   // Owner picks software or controller settings
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         pull_out <= 4'h0;
      else if (sw_own_in)
         pull_out <= sw_pull_in;
      else
         pull_out <= hw_pull_in;
   end
endmodule // uolc_pull_mux
`default_nettype wire

// ### src/uolc_line_ctrl.sv
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none
// Functional notes
// - Bit 7 enables the D+ pull-up.
// - Bit 6 enables the D- pull-up.
// - Bit 5 enables the D+ pull-down.
// - Bit 4 enables the D- pull-down.
// - Bit 3 powers VBUS.
// - Bit 2 set: pulls follow software bits 7..4.
// - Bit 2 clear: pulls follow the USB hardware controller.
// - Bit 1 charges VBUS through a pull-up resistor.
// - Bit 0 discharges VBUS through a pull-down resistor.
// - Bits 31..8 read zero and ignore writes.
module uolc_line_ctrl
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // USB controller pull requests {dp_up, dm_up, dp_dn, dm_dn}
   input wire logic [3:0] hw_pull_in,
   // Line controls
   output logic dplus_pullup_enable_out,
   output logic dminus_pullup_enable_out,
   output logic dplus_pulldown_enable_out,
   output logic dminus_pulldown_enable_out,
   output logic vbus_power_on_out,
   output logic vbus_charge_enable_out,
   output logic vbus_discharge_enable_out
);
   logic [7:0] ctrl_ff;
   logic [7:0] nxt_ctrl;
   uolc_pkg::uolc_bus_e bus_ff;
   uolc_pkg::uolc_bus_e nxt_bus;
   logic [3:0] pull_sel;
   logic [2:0] vbus_ff;
   logic wr_hit;
   logic req;

   // Address decode
   function automatic logic is_ctrl(input logic [7:0] a);
      is_ctrl = (a == uolc_pkg::REG_CTRL_OFS);
   endfunction

   assign req = avs_read_in | avs_write_in;
   assign wr_hit = (bus_ff == uolc_pkg::UOLC_ACK) & avs_write_in & is_ctrl(avs_address_in);

   // Bus handshake: one wait cycle, then release
   always_comb
   begin
      nxt_bus = bus_ff;
      unique case (bus_ff)
         uolc_pkg::UOLC_IDLE: if (req) nxt_bus = uolc_pkg::UOLC_ACK;
         uolc_pkg::UOLC_ACK: nxt_bus = uolc_pkg::UOLC_DONE;
         uolc_pkg::UOLC_DONE: nxt_bus = uolc_pkg::UOLC_IDLE;
         default: nxt_bus = uolc_pkg::UOLC_IDLE;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         bus_ff <= uolc_pkg::UOLC_IDLE;
      else
         bus_ff <= nxt_bus;
   end

   // Waitrequest low only in the acknowledge cycle
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         avs_waitrequest_out <= 1'b1;
      else
         avs_waitrequest_out <= ~(nxt_bus == uolc_pkg::UOLC_ACK);
   end

   // Control register write, low byte lane only
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      if (wr_hit && avs_byteenable_in[0])
         nxt_ctrl = avs_writedata_in[7:0];
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         ctrl_ff <= uolc_pkg::REG_CTRL_RST;
      else
         ctrl_ff <= nxt_ctrl;
   end

   // Read data, prepared as waitrequest falls
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         avs_readdata_out <= uolc_pkg::UNMAPPED_RD;
      else if (nxt_bus == uolc_pkg::UOLC_ACK && avs_read_in)
      begin
         if (is_ctrl(avs_address_in))
            avs_readdata_out <= {24'h000000, nxt_ctrl};
         else if (avs_address_in == uolc_pkg::REG_STAT_OFS)
            avs_readdata_out <= {24'h000000, 3'h0, ctrl_ff[uolc_pkg::OWN_BIT], pull_sel};
         else
            avs_readdata_out <= uolc_pkg::UNMAPPED_RD;
      end
   end

   // Pull selection between software and controller
   uolc_pull_mux u_pull_mux
   (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .sw_own_in(ctrl_ff[uolc_pkg::OWN_BIT]),
      .sw_pull_in(ctrl_ff[7:4]),
      .hw_pull_in(hw_pull_in),
      .pull_out(pull_sel)
   );

   // Pull outputs
   assign dplus_pullup_enable_out = pull_sel[3];
   assign dminus_pullup_enable_out = pull_sel[2];
   assign dplus_pulldown_enable_out = pull_sel[1];
   assign dminus_pulldown_enable_out = pull_sel[0];

   // VBUS controls, registered
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         vbus_ff <= 3'h0;
      else
         vbus_ff <= {ctrl_ff[uolc_pkg::VON_BIT], ctrl_ff[uolc_pkg::CHG_BIT], ctrl_ff[uolc_pkg::DIS_BIT]};
   end

   assign vbus_power_on_out = vbus_ff[2];
   assign vbus_charge_enable_out = vbus_ff[1];
   assign vbus_discharge_enable_out = vbus_ff[0];

   // Assertions
   property p_dpu;
      @(posedge clk_in) disable iff (srst_in)
      ctrl_ff[uolc_pkg::OWN_BIT] |=> dplus_pullup_enable_out == $past(ctrl_ff[uolc_pkg::DPU_BIT]);
   endproperty
   a_dpu: assert property (p_dpu) else $error("dp pullup mismatch");
   property p_dmu;
      @(posedge clk_in) disable iff (srst_in)
      ctrl_ff[uolc_pkg::OWN_BIT] |=> dminus_pullup_enable_out == $past(ctrl_ff[uolc_pkg::DMU_BIT]);
   endproperty
   a_dmu: assert property (p_dmu) else $error("dm pullup mismatch");
   property p_dpd;
      @(posedge clk_in) disable iff (srst_in)
      ctrl_ff[uolc_pkg::OWN_BIT] |=> dplus_pulldown_enable_out == $past(ctrl_ff[uolc_pkg::DPD_BIT]);
   endproperty
   a_dpd: assert property (p_dpd) else $error("dp pulldown mismatch");
   property p_dmd;
      @(posedge clk_in) disable iff (srst_in)
      ctrl_ff[uolc_pkg::OWN_BIT] |=> dminus_pulldown_enable_out == $past(ctrl_ff[uolc_pkg::DMD_BIT]);
   endproperty
   a_dmd: assert property (p_dmd) else $error("dm pulldown mismatch");
   property p_von;
      @(posedge clk_in) disable iff (srst_in)
      ##1 vbus_power_on_out == $past(ctrl_ff[uolc_pkg::VON_BIT]);
   endproperty
   a_von: assert property (p_von) else $error("vbus power mismatch");
   property p_hw;
      @(posedge clk_in) disable iff (srst_in)
      !ctrl_ff[uolc_pkg::OWN_BIT] |=> pull_sel == $past(hw_pull_in);
   endproperty
   a_hw: assert property (p_hw) else $error("hw pull not followed");
   property p_chg;
      @(posedge clk_in) disable iff (srst_in)
      ##1 vbus_charge_enable_out == $past(ctrl_ff[uolc_pkg::CHG_BIT]);
   endproperty
   a_chg: assert property (p_chg) else $error("vbus charge mismatch");
   property p_dis;
      @(posedge clk_in) disable iff (srst_in)
      ##1 vbus_discharge_enable_out == $past(ctrl_ff[uolc_pkg::DIS_BIT]);
   endproperty
   a_dis: assert property (p_dis) else $error("vbus discharge mismatch");
   property p_rd;
      @(posedge clk_in) disable iff (srst_in)
      (!avs_waitrequest_out && avs_read_in && is_ctrl(avs_address_in))
         |-> avs_readdata_out == {24'h000000, ctrl_ff};
   endproperty
   a_rd: assert property (p_rd) else $error("read data mismatch");
   property p_wr;
      @(posedge clk_in) disable iff (srst_in)
      (!avs_waitrequest_out && avs_write_in && is_ctrl(avs_address_in) && avs_byteenable_in[0])
         |=> ctrl_ff == $past(avs_writedata_in[7:0]);
   endproperty
   a_wr: assert property (p_wr) else $error("write not stored");
   property p_wait;
      @(posedge clk_in) disable iff (srst_in)
      $rose(req) && avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out;
   endproperty
   a_wait: assert property (p_wait) else $error("no bus answer");
   c_wr: cover property (@(posedge clk_in) disable iff (srst_in) wr_hit);
   c_sw: cover property (@(posedge clk_in) disable iff (srst_in) $rose(ctrl_ff[uolc_pkg::OWN_BIT]));
   c_rd: cover property (@(posedge clk_in) disable iff (srst_in) !avs_waitrequest_out && avs_read_in);
endmodule // uolc_line_ctrl
`default_nettype wire

// ### tb/uolc_usb_ctrl_model.sv
`default_nettype none
// USB controller side of the pull selection
module uolc_usb_ctrl_model
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Pull choice from the bench
   input wire logic [3:0] req_in,
   // Pull requests to the line block
   output logic [3:0] hw_pull_out
);
   // Controller registers its pull choice
   always_ff @(posedge clk_in)
   begin
      if (srst_in) hw_pull_out <= 4'h0;
      else hw_pull_out <= req_in;
   end
endmodule // uolc_usb_ctrl_model
`default_nettype wire

// ### tb/usb_otg_line_control_tb.sv
`default_nettype none
module usb_otg_line_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, srst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [7:0] avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, rd;
   logic [3:0] avs_byteenable_in, hw_req, hw_pull, pulls;
   logic [2:0] vbus;
   int mismatches = 0;
   int checks_done = 0;
   // Controller model and block
   uolc_usb_ctrl_model i_ctrl (.clk_in(clk_in), .srst_in(srst_in), .req_in(hw_req), .hw_pull_out(hw_pull));
   uolc_line_ctrl i_dut (.clk_in(clk_in), .srst_in(srst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .hw_pull_in(hw_pull),
      .dplus_pullup_enable_out(pulls[3]), .dminus_pullup_enable_out(pulls[2]),
      .dplus_pulldown_enable_out(pulls[1]), .dminus_pulldown_enable_out(pulls[0]),
      .vbus_power_on_out(vbus[2]), .vbus_charge_enable_out(vbus[1]), .vbus_discharge_enable_out(vbus[0]));
   // Verdict and end of run
   task test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One bus cycle, held until waitrequest is sampled low
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      // Only the watchdog ends a wait that never comes
      do
      begin
         @(posedge clk_in);
      end
      while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (exp !== got)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task test_reset();
      bus(1'b0, 8'h00, 32'h0, 4'hf);
      chk("ctrl", 32'h0, rd);
      chk("lines", 32'h0, {pulls, vbus});
      $display("test reset done");
   endtask
   task test_sw_pulls();
      hw_req <= 4'h0;
      for (int b = 4; b < 8; b++)
      begin
         bus(1'b1, 8'h00, (32'h1 << b) | 32'h4, 4'hf);
         repeat (4) @(posedge clk_in);
         chk("pulls", 32'h1 << (b - 4), {28'h0, pulls});
         bus(1'b0, 8'h00, 32'h0, 4'hf);
         chk("ctrl", (32'h1 << b) | 32'h4, rd);
      end
      $display("test sw_pulls done");
   endtask
   task test_vbus();
      int bits [3] = '{3, 1, 0};
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b1, 8'h00, 32'h1 << bits[i], 4'hf);
         repeat (4) @(posedge clk_in);
         chk("vbus", 32'h4 >> i, {29'h0, vbus});
      end
      $display("test vbus done");
   endtask
   task test_hw();
      hw_req <= 4'h5;
      bus(1'b1, 8'h00, 32'ha0, 4'hf);
      repeat (4) @(posedge clk_in);
      chk("pulls", 32'h5, {28'h0, pulls});
      bus(1'b0, 8'h00, 32'h0, 4'hf);
      chk("ctrl", 32'ha0, rd);
      hw_req <= 4'ha;
      repeat (4) @(posedge clk_in);
      chk("pulls", 32'ha, {28'h0, pulls});
      bus(1'b0, 8'h04, 32'h0, 4'hf);
      chk("status", 32'h0a, rd);
      $display("test hw done");
   endtask
   task test_upper();
      bus(1'b1, 8'h00, 32'hffff_ff0c, 4'hf);
      bus(1'b0, 8'h00, 32'h0, 4'hf);
      chk("ctrl", 32'h0c, rd);
      bus(1'b1, 8'h00, 32'h03, 4'h0);
      bus(1'b0, 8'h00, 32'h0, 4'hf);
      chk("ctrl", 32'h0c, rd);
      bus(1'b0, 8'h10, 32'h0, 4'hf);
      chk("unmapped", 32'h0, rd);
      $display("test upper done");
   endtask
   // Clock
   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   // Watchdog
   initial
   begin
      #50us;
      mismatches++;
      test_done();
   end
   // Main sequence
   initial
   begin
      {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
      avs_byteenable_in = 4'hf;
      hw_req = 4'h0;
      srst_in = 1'b1;
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      test_reset();
      test_sw_pulls();
      test_vbus();
      test_hw();
      test_upper();
      test_done();
   end
endmodule // usb_otg_line_control_tb
`default_nettype wire
